// ==== bench/dsp_dispatch_ctrl_test.sv ====
// Self-checking bench for the dispatch, barrier and privilege controller.
// Assumes the bench plays decode and a simple in-order execute stage.
`timescale 1ns/10ps
module dsp_dispatch_ctrl_test;
  import dsp_pkg::*;
  localparam logic [9:0] F_PRIV = 10'h200, F_MSRW = 10'h0a0, F_SC = 10'h110, F_LOAD = 10'h004;
  localparam logic [9:0] F_SPEC = 10'h005, F_DCR = 10'h002, F_BAR = 10'h0c0, F_CTX = 10'h180;
  logic        i_core_clk, i_rstn, i_dec_valid, i_mispredict, i_mem_idle, i_ex_report, hold_rep;
  logic        o_dec_ready, o_issue_valid, o_issue_user, o_flush, o_trap, o_priv_level;
  logic        o_barrier_busy, i_exc_pending, i_ex_ready;
  logic [9:0]  fl;
  logic [15:0] o_trap_vector;
  logic [31:0] msr_dat, o_machine_state_register;
  dsp_exc_t    o_trap_cause;
  int          err_count, n_checks, pend;
  dsp_dispatch_ctrl dut_u (
    .i_core_clk, .i_rstn, .i_dec_valid, .i_dec_priv(fl[9]), .i_dec_ctx_sync(fl[8]),
    .i_dec_exec_sync(fl[7]), .i_dec_storage_bar(fl[6]), .i_dec_msr_write(fl[5]),
    .i_dec_syscall(fl[4]), .i_dec_int_return(fl[3]), .i_dec_load(fl[2]),
    .i_dec_dcr_access(fl[1]), .i_dec_speculative(fl[0]), .i_dec_msr_data(msr_dat),
    .i_dec_saved_msr(32'h0000_0000), .i_ex_ready, .i_ex_report, .i_ex_complete(1'b0),
    .i_mispredict, .i_exc_pending, .i_async_exc(1'b0), .i_mem_idle, .o_dec_ready,
    .o_issue_valid, .o_issue_user, .o_flush, .o_trap, .o_trap_cause, .o_trap_vector,
    .o_priv_level, .o_machine_state_register, .o_barrier_busy);
  // ----------------------------------------------------------------
  // Clock, execute stage and shared tasks
  // ----------------------------------------------------------------
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  // Reports one issued instruction a cycle unless held, so barriers can be stalled
  always @(posedge i_core_clk) begin
    #1;
    if (o_issue_valid === 1'b1) pend++;
    i_ex_report = (pend > 0) && !hold_rep;
    if (i_ex_report) pend--;
  end
  task automatic report_and_stop();
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk1(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin err_count++; $display("CHECK FAILED %0t bit %b not %b", $time, g, e); end
  endtask
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin err_count++; $display("CHECK FAILED %0t value %h not %h", $time, g, e); end
  endtask
  task automatic tick();
    @(posedge i_core_clk);
    #1;
  endtask
  task automatic stuck();
    err_count++;
    $display("CHECK FAILED %0t wait ran out", $time);
    report_and_stop();
  endtask
  task automatic take(input logic [9:0] f);
    int k;
    fl = f;
    i_dec_valid = 1'b1;
    for (k = 0; k < 40; k++) begin
      #2;
      if (o_dec_ready === 1'b1) break;
      tick();
    end
    if (k == 40) stuck();
    tick();
    i_dec_valid = 1'b0;
    fl = 10'h000;
  endtask
  task automatic refused(input logic [9:0] f);
    fl = f;
    i_dec_valid = 1'b1;
    repeat (3) begin
      tick();
      chk1(o_dec_ready, 1'b0);
    end
    i_dec_valid = 1'b0;
    tick();
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 40 && o_barrier_busy !== 1'b0; k++) tick();
    if (k == 40) stuck();
  endtask
  task automatic wait_trap(input dsp_exc_t c, input logic [15:0] v);
    int k;
    for (k = 0; k < 40 && o_trap !== 1'b1; k++) tick();
    if (k == 40) stuck();
    chk16({14'h0000, o_trap_cause}, {14'h0000, c});
    chk16(o_trap_vector, v);
    wait_idle();
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_plain();
    chk1(o_priv_level, PRIV_LVL_RESET);
    chk1(o_machine_state_register[MSR_PRIV_POS], PRIV_LVL_PRIVILEGED);
    take(10'h000);
    chk1(o_issue_valid, 1'b1);
    chk1(o_issue_user, PRIV_LVL_PRIVILEGED);
    take(F_PRIV);
    chk1(o_issue_valid, 1'b1);
  endtask
  task automatic t_refusals();
    i_mem_idle = 1'b0;
    refused(F_DCR);
    i_mem_idle = 1'b1;
    take(F_DCR);
    refused(F_SPEC);
    i_ex_ready = 1'b0;
    refused(10'h000);
    i_ex_ready = 1'b1;
    take(F_LOAD);
    i_mispredict = 1'b1;
    tick();
    i_mispredict = 1'b0;
    chk1(o_flush, 1'b1);
  endtask
  task automatic t_state_write();
    hold_rep = 1'b1;
    take(10'h000);
    msr_dat = 32'h0000_0001 << MSR_PRIV_POS;
    take(F_MSRW);
    repeat (4) begin
      chk1(o_issue_valid, 1'b0);
      chk1(o_barrier_busy, 1'b1);
      tick();
    end
    hold_rep = 1'b0;
    wait_idle();
    chk1(o_priv_level, PRIV_LVL_USER);
    take(10'h000);
    chk1(o_issue_user, PRIV_LVL_USER);
    for (int i = 0; i < 2; i++) begin
      take(i == 0 ? F_BAR : F_CTX);
      chk1(o_barrier_busy, 1'b1);
      wait_idle();
    end
  endtask
  task automatic t_traps();
    take(F_PRIV);
    wait_trap(DSP_EXC_PRIV, PROGRAM_VECTOR);
    chk1(o_priv_level, PRIV_LVL_PRIVILEGED);
    i_exc_pending = 1'b1;
    take(F_SC);
    repeat (3) begin
      chk1(o_trap, 1'b0);
      tick();
    end
    i_exc_pending = 1'b0;
    wait_trap(DSP_EXC_SYSCALL, 16'h0000);
  endtask
  initial begin
    {i_rstn, i_dec_valid, i_mispredict, hold_rep, i_exc_pending} = 5'h00;
    i_ex_ready = 1'b1;
    err_count = 0;
    n_checks = 0;
    fl = 10'h000;
    msr_dat = 32'h0000_0000;
    i_mem_idle = 1'b1;
    repeat (5) @(posedge i_core_clk);
    #1 i_rstn = 1'b1;
    t_reset_plain();
    t_refusals();
    t_state_write();
    t_traps();
    report_and_stop();
  end
endmodule // dsp_dispatch_ctrl_test

// ==== bench/dsp_dispatch_monitor.sv ====
// Port-level checks for the dispatch, barrier and privilege controller.
// Assumes one core clock and the synchronous active-low core reset.
`timescale 1ns/10ps
module dsp_dispatch_monitor
  import dsp_pkg::*;
(
  input wire logic                 i_core_clk,
  input wire logic                 i_rstn,
  input wire logic                 i_dec_valid,
  input wire logic                 i_dec_load,
  input wire logic                 i_dec_dcr_access,
  input wire logic                 i_dec_speculative,
  input wire logic                 i_mem_idle,
  input wire logic                 i_mispredict,
  input wire logic                 o_dec_ready,
  input wire logic                 o_issue_valid,
  input wire logic                 o_issue_user,
  input wire logic                 o_flush,
  input wire logic                 o_trap,
  input wire dsp_exc_t             o_trap_cause,
  input wire logic [15:0]          o_trap_vector,
  input wire logic                 o_priv_level,
  input wire logic [MSR_WIDTH-1:0] o_machine_state_register,
  input wire logic                 o_barrier_busy
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // ----------------------------------------------------------------
  // Sequences and checks
  // ----------------------------------------------------------------
  sequence s_take;
    i_dec_valid && o_dec_ready;
  endsequence
  sequence s_plain_issue;
    s_take ##1 o_issue_valid;
  endsequence
  chk_plain_issue: assert property (s_take |=> o_issue_valid || o_barrier_busy)
    else $error("taken instruction neither issued nor held");
  chk_issue_mode: assert property (s_plain_issue |-> o_issue_user == $past(o_priv_level))
    else $error("issue mode differs from mode at take");
  chk_priv_mirror: assert property (o_priv_level == o_machine_state_register[MSR_PRIV_POS])
    else $error("privilege output differs from state bit");
  // Reset itself is the antecedent here, so the default disable is overridden
  chk_reset_priv: assert property (disable iff (1'b0) !i_rstn |=> !o_priv_level)
    else $error("reset left user mode");
  chk_trap_vector: assert property (o_trap && o_trap_cause == DSP_EXC_PRIV |->
    o_trap_vector == PROGRAM_VECTOR) else $error("privilege trap with wrong vector");
  chk_spec_load: assert property (i_dec_valid && i_dec_load && i_dec_speculative |->
    !o_dec_ready) else $error("speculative load taken");
  chk_dcr_order: assert property (i_dec_valid && i_dec_dcr_access && !i_mem_idle |->
    !o_dec_ready) else $error("device register access taken with memory busy");
  chk_busy_halt: assert property (o_barrier_busy |-> !o_dec_ready)
    else $error("instruction taken while barrier busy");
  chk_flush_pulse: assert property (i_mispredict |=> o_flush)
    else $error("mispredict without flush");
endmodule // dsp_dispatch_monitor

bind dsp_dispatch_ctrl dsp_dispatch_monitor mon_u (
  .i_core_clk, .i_rstn, .i_dec_valid, .i_dec_load, .i_dec_dcr_access, .i_dec_speculative,
  .i_mem_idle, .i_mispredict, .o_dec_ready, .o_issue_valid, .o_issue_user, .o_flush, .o_trap,
  .o_trap_cause, .o_trap_vector, .o_priv_level, .o_machine_state_register, .o_barrier_busy
);

// ==== hdl/dsp_dispatch_ctrl.sv ====
// In-order dispatch controller with sync barriers and privilege checking.
// Assumes decode tags each instruction; execute reports completion and exception-report points.
//
// Summary of operation
// - Issue and complete strictly in program order.
// - Speculate past branches, flush on mispredict.
// - Never issue loads speculatively; no coherency.
// - Context sync recognized stops further issue.
// - Dispatch context sync after older exceptions report.
// - Context barrier completes after older exceptions report.
// - Older instructions keep their starting context.
// - Younger instructions use the new context.
// - Exceptional sync waits for higher-priority exceptions.
// - System call, interrupt returns, exceptions are context sync.
// - Storage barrier provided to order memory accesses.
// - Execution sync halts and waits for drain.
// - Storage barrier, state writes, context sync are execution sync.
// - Execution-sync context change applies by next context sync.
// - Device register accesses ordered like memory accesses.
// - Privilege bit zero privileged, one user.
// - Reset clears privilege bit to privileged.
// - Privileged instruction in user mode traps to 0x0700; privileged context sync or interrupt return traps as system call to 0x0000.
// - Privileged mode allows every instruction.
// - User resources accessible in both modes.
// - User mode blocks privileged-only resources.
`timescale 1ns/10ps

module dsp_dispatch_ctrl
  import dsp_pkg::*;
#(
  parameter int DEPTH = INFLIGHT_DEPTH
) (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rstn,
  // Decoded instruction offered by fetch/decode
  input  wire logic                 i_dec_valid,
  input  wire logic                 i_dec_priv,
  input  wire logic                 i_dec_ctx_sync,
  input  wire logic                 i_dec_exec_sync,
  input  wire logic                 i_dec_storage_bar,
  input  wire logic                 i_dec_msr_write,
  input  wire logic                 i_dec_syscall,
  input  wire logic                 i_dec_int_return,
  input  wire logic                 i_dec_load,
  input  wire logic                 i_dec_dcr_access,
  input  wire logic                 i_dec_speculative,
  input  wire logic [MSR_WIDTH-1:0] i_dec_msr_data,
  input  wire logic [MSR_WIDTH-1:0] i_dec_saved_msr,
  // Execute-side feedback
  input  wire logic                 i_ex_ready,
  input  wire logic                 i_ex_report,
  input  wire logic                 i_ex_complete,
  input  wire logic                 i_mispredict,
  input  wire logic                 i_exc_pending,
  input  wire logic                 i_async_exc,
  input  wire logic                 i_mem_idle,
  // Outputs
  output logic                      o_dec_ready,
  output logic                      o_issue_valid,
  output logic                      o_issue_user,
  output logic                      o_flush,
  output logic                      o_trap,
  output dsp_exc_t                  o_trap_cause,
  output logic [15:0]               o_trap_vector,
  output logic                      o_priv_level,
  output logic [MSR_WIDTH-1:0]      o_machine_state_register,
  output logic                      o_barrier_busy
);

  localparam int CW = $clog2(DEPTH + 1);

  // ---------------------------------------------------------------
  // Instruction classification
  // ---------------------------------------------------------------
  dsp_state_t         state;
  dsp_state_t         next_state;
  logic [CW-1:0]      inflight;
  logic [CW-1:0]      next_inflight;
  logic [MSR_WIDTH-1:0] machine_state_register;
  logic [MSR_WIDTH-1:0] pending_msr;
  logic               pending_valid;
  logic               bar_ctx;
  logic               bar_exc;
  logic               bar_pending_msr;
  logic [MSR_WIDTH-1:0] bar_msr;

  wire  user_mode     = machine_state_register[MSR_PRIV_POS] == PRIV_LVL_USER;
  wire  priv_fault    = i_dec_priv && user_mode;
  wire  is_ctx        = i_dec_ctx_sync || i_dec_syscall || i_dec_int_return;
  wire  is_sync       = is_ctx || i_dec_exec_sync || i_dec_storage_bar
                        || i_dec_msr_write || priv_fault;
  wire  spec_load     = i_dec_load && i_dec_speculative;
  wire  dcr_order     = i_dec_dcr_access && !i_mem_idle;
  wire  drained       = (inflight == '0);
  wire  full          = (inflight == CW'(DEPTH));
  wire  run_ok        = (state == DSP_RUN) && !i_mispredict && !i_async_exc;
  wire  plain_go      = run_ok && i_dec_valid && !is_sync && !spec_load
                        && !dcr_order && !full && i_ex_ready;
  wire  bar_take      = run_ok && i_dec_valid && is_sync;
  wire  bar_start_ok  = drained && !i_exc_pending;
  wire  bar_go        = (state == DSP_ISSUE_BAR) && i_ex_ready && !bar_exc;
  wire  issue_fire    = plain_go || bar_go;
  wire  bar_msr_fire  = bar_go && bar_pending_msr;

  // ---------------------------------------------------------------
  // Barrier sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      DSP_RUN: begin
        if (bar_take) begin
          next_state = DSP_DRAIN;
        end
      end
      DSP_DRAIN: begin
        if (bar_start_ok) begin
          next_state = DSP_ISSUE_BAR;
        end
      end
      DSP_ISSUE_BAR: begin
        if (bar_exc) begin
          next_state = DSP_RUN;
        end else if (i_ex_ready) begin
          next_state = DSP_WAIT_DONE;
        end
      end
      DSP_WAIT_DONE: begin
        if (drained) begin
          next_state = DSP_RUN;
        end
      end
    endcase
  end

  // Occupancy: one entry per issue, released when report point reached
  wire rel = i_ex_report && (inflight != '0);
  always_comb begin
    next_inflight = inflight;
    if (i_mispredict) begin
      next_inflight = '0;
    end else if (issue_fire && !rel) begin
      next_inflight = inflight + CW'(1);
    end else if (!issue_fire && rel) begin
      next_inflight = inflight - CW'(1);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      state    <= DSP_RUN;
      inflight <= '0;
    end else begin
      state    <= next_state;
      inflight <= next_inflight;
    end
  end

  // ---------------------------------------------------------------
  // Captured barrier attributes
  // ---------------------------------------------------------------
  wire [MSR_WIDTH-1:0] take_msr = i_dec_int_return ? i_dec_saved_msr : i_dec_msr_data;
  // A faulting barrier must never load a new state value
  wire                 next_bar_exc      = priv_fault || i_dec_syscall;
  wire                 next_bar_pend_msr = !priv_fault
                                           && (i_dec_msr_write || i_dec_int_return);

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      bar_ctx         <= 1'b0;
      bar_exc         <= 1'b0;
      bar_pending_msr <= 1'b0;
      bar_msr         <= MSR_RESET;
    end else if (bar_take) begin
      bar_ctx         <= is_ctx;
      bar_exc         <= next_bar_exc;
      bar_pending_msr <= next_bar_pend_msr;
      bar_msr         <= take_msr;
    end
  end

  // ---------------------------------------------------------------
  // Machine state and context switching
  // ---------------------------------------------------------------
  // A state write from an execution-sync barrier is parked and applied once
  // that barrier drains, so younger plain instructions never see a half-switch.
  wire ctx_point  = (state == DSP_WAIT_DONE) && drained && bar_ctx;
  wire trap_point = (state == DSP_ISSUE_BAR) && bar_exc;
  wire ctx_apply  = ctx_point || trap_point;

  logic [MSR_WIDTH-1:0] next_machine_state_register;
  logic [MSR_WIDTH-1:0] next_pending_msr;
  logic                 next_pending_valid;
  wire                  plain_drain_apply = (state == DSP_WAIT_DONE) && drained;

  // Trap wins over any parked value; the handler always starts privileged
  always_comb begin
    next_machine_state_register = machine_state_register;
    next_pending_msr            = pending_msr;
    next_pending_valid          = pending_valid;
    if (bar_msr_fire && !bar_ctx) begin
      next_pending_msr   = bar_msr;
      next_pending_valid = 1'b1;
    end
    if (trap_point) begin
      next_machine_state_register[MSR_PRIV_POS] = PRIV_LVL_PRIVILEGED;
      next_pending_valid                        = 1'b0;
    end else if (ctx_point && bar_pending_msr) begin
      next_machine_state_register = bar_msr;
      next_pending_valid          = 1'b0;
    end else if (ctx_apply && pending_valid) begin
      next_machine_state_register = pending_msr;
      next_pending_valid          = 1'b0;
    end else if (plain_drain_apply && pending_valid) begin
      next_machine_state_register = pending_msr;
      next_pending_valid          = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      machine_state_register <= MSR_RESET;
      pending_msr            <= MSR_RESET;
      pending_valid          <= 1'b0;
    end else begin
      machine_state_register <= next_machine_state_register;
      pending_msr            <= next_pending_msr;
      pending_valid          <= next_pending_valid;
    end
  end

  // ---------------------------------------------------------------
  // Issue and trap outputs
  // ---------------------------------------------------------------
  // Issue user tag is sampled at issue time so older work keeps its context.
  wire        next_issue_valid = issue_fire && !i_mispredict;
  wire        next_trap_priv   = trap_point && !bar_ctx;
  wire        next_trap_sc     = trap_point && bar_ctx;
  wire [15:0] next_trap_vector = next_trap_priv ? PROGRAM_VECTOR : 16'h0000;
  dsp_exc_t   next_trap_cause;

  assign next_trap_cause = next_trap_priv ? DSP_EXC_PRIV :
                           (next_trap_sc ? DSP_EXC_SYSCALL : DSP_EXC_NONE);

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_issue_valid <= 1'b0;
      o_issue_user  <= 1'b0;
    end else begin
      o_issue_valid <= next_issue_valid;
      o_issue_user  <= user_mode;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_flush <= 1'b0;
    end else begin
      o_flush <= i_mispredict;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_trap        <= 1'b0;
      o_trap_cause  <= DSP_EXC_NONE;
      o_trap_vector <= 16'h0000;
    end else begin
      o_trap        <= trap_point;
      o_trap_cause  <= next_trap_cause;
      o_trap_vector <= next_trap_vector;
    end
  end

  assign o_dec_ready              = plain_go || bar_take;
  assign o_priv_level             = machine_state_register[MSR_PRIV_POS];
  assign o_machine_state_register = machine_state_register;
  assign o_barrier_busy           = (state != DSP_RUN);

endmodule // dsp_dispatch_ctrl

// ==== include/dsp_pkg.sv ====
// Shared constants and types for the dispatch, barrier and privilege control block.
// Assumes a single core clock domain; decode sits upstream, execute downstream.
package dsp_pkg;

  // Privilege-level bit encoding
  localparam logic       PRIV_LVL_PRIVILEGED = 1'b0;
  localparam logic       PRIV_LVL_USER       = 1'b1;
  localparam logic       PRIV_LVL_RESET      = 1'b0;

  // Program interrupt vector offset
  localparam logic [15:0] PROGRAM_VECTOR     = 16'h0700;

  // Machine-state register layout used here
  localparam int          MSR_WIDTH          = 32;
  localparam int          MSR_PRIV_POS       = 17;
  localparam logic [31:0] MSR_RESET          = 32'h0000_0000;

  // Default depth of the in-flight tracking
  localparam int          INFLIGHT_DEPTH     = 4;

  // Exception cause codes reported with a trap
  typedef enum logic [1:0] {
    DSP_EXC_NONE,
    DSP_EXC_PRIV,
    DSP_EXC_SYSCALL
  } dsp_exc_t;

  // Dispatch controller state
  typedef enum logic [1:0] {
    DSP_RUN,
    DSP_DRAIN,
    DSP_ISSUE_BAR,
    DSP_WAIT_DONE
  } dsp_state_t;

endpackage : dsp_pkg
